// ==== scan_trig_pkg.sv ====
// package: register map, field layouts, encodings and reset values of the scan trigger control block
package scan_trig_pkg;

  // register byte offsets
  localparam logic [7:0] REG_CMD     = 8'h00; // command strobe register (write)
  localparam logic [7:0] REG_SRCSEL  = 8'h04; // pending trigger source selection
  localparam logic [7:0] REG_LIST    = 8'h08; // channel list first/last
  localparam logic [7:0] REG_STATE   = 8'h0c; // run state, active source, channel
  localparam logic [7:0] REG_SRCNAME = 8'h10; // active source name, ascii
  localparam logic [7:0] REG_INTSTAT = 8'h14; // sticky event bits, write one to clear
  localparam logic [7:0] REG_INTMASK = 8'h18; // interrupt mask
  localparam logic [7:0] REG_ARMCNT  = 8'h1c; // arm count, continuous initiation

  // command register bit positions
  localparam int CMD_INIT  = 0; // arm scanning, activate pending source
  localparam int CMD_SWTRG = 1; // software trigger
  localparam int CMD_BUSTRG = 2; // common trigger command
  localparam int CMD_GRPTRG = 3; // group execute trigger message
  localparam int CMD_RESET = 4; // reset command
  localparam int CMD_CLS   = 5; // clear status
  localparam int CMD_ABORT = 6; // stop scanning
  localparam int CMD_W     = 7;

  // event bit positions in status and mask
  localparam int EV_ADV     = 0; // scan advanced
  localparam int EV_DONE    = 1; // scan cycle complete
  localparam int EV_EXTERR  = 2; // external input refused
  localparam int EV_TRGERR  = 3; // trigger ignored
  localparam int EV_W       = 4;

  // channel field layout
  localparam int CH_W       = 4;
  localparam int LIST_LAST  = 8;  // last channel field position
  localparam int LIST_VALID = 16; // list valid bit
  localparam int ARM_W      = 8;
  localparam int ARM_CONT   = 16; // continuous initiation bit
  localparam logic [ARM_W-1:0] ARM_RST = 8'h01;

  // shared external input owners
  localparam int NBOX   = 4;
  localparam int BOX_W  = 2;

  // trigger source encodings
  typedef enum logic [1:0] {
    SRC_BUS  = 2'b00,
    SRC_EXT  = 2'b01,
    SRC_HOLD = 2'b10,
    SRC_IMM  = 2'b11
  } trig_src_e;

  // ascii names returned by the source query
  localparam logic [31:0] NAME_BUS  = 32'h00425553;
  localparam logic [31:0] NAME_EXT  = 32'h00455854;
  localparam logic [31:0] NAME_HOLD = 32'h484f4c44;
  localparam logic [31:0] NAME_IMM  = 32'h00494d4d;

endpackage

// ==== ext_trig_arbiter.sv ====
// module: arbiter granting the shared external trigger input to one switchbox
`timescale 1ns/1ps
`default_nettype none
module ext_trig_arbiter
  import scan_trig_pkg::*;
(
  input  wire logic                   clk_sys,   // system clock
  input  wire logic                   arst_n,    // async reset, active low
  input  wire logic [scan_trig_pkg::NBOX-1:0] claim,   // one-cycle claim pulses
  input  wire logic [scan_trig_pkg::NBOX-1:0] relPulse, // one-cycle release pulses
  output logic      [scan_trig_pkg::NBOX-1:0] owner,   // current owner, one-hot
  output logic      [scan_trig_pkg::NBOX-1:0] refuse   // claim refused this cycle
);

  logic [NBOX-1:0] owner_r;
  logic [NBOX-1:0] owner_nxt;
  logic [NBOX-1:0] refuse_c;

  // lowest index wins a tie so that at most one box is ever granted
  always_comb begin
    logic taken;
    taken     = 1'b0;
    owner_nxt = owner_r & ~relPulse;
    refuse_c  = '0;
    for (int i = 0; i < NBOX; i++) begin
      if (owner_nxt[i]) begin
        taken = 1'b1;
      end
    end
    for (int i = 0; i < NBOX; i++) begin
      if (claim[i] && !owner_nxt[i]) begin
        if (taken) begin
          refuse_c[i] = 1'b1;
        end else begin
          owner_nxt[i] = 1'b1;
          taken        = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      owner_r <= '0;
    end else begin
      owner_r <= owner_nxt;
    end
  end

  assign owner  = owner_r;
  assign refuse = refuse_c;

endmodule
`default_nettype wire

// ==== ext_pulse_sync.sv ====
// module: two-stage synchroniser and rising edge detector for the external trigger pin
`timescale 1ns/1ps
`default_nettype none
module ext_pulse_sync (
  input  wire logic clk_sys,  // system clock
  input  wire logic arst_n,   // async reset, active low
  input  wire logic pinIn,    // asynchronous pin
  output logic      risePulse // one-cycle pulse on a synchronised rising edge
);

  logic [2:0] stage_r;
  logic [2:0] stage_nxt;

  // stage 0 feeds only stage 1; the edge is seen between stages 1 and 2
  always_comb begin
    stage_nxt = {stage_r[1:0], pinIn};
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stage_r <= '0;
    end else begin
      stage_r <= stage_nxt;
    end
  end

  assign risePulse = stage_r[1] & ~stage_r[2];

endmodule
`default_nettype wire

// ==== scan_trigger_source_control.sv ====
// module: trigger source selection, scan arming and advance, with apb registers and interrupt
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - software trigger works only for hold or bus
// - trigger needs channel list and initiate first
// - triggering leaves the source setting unchanged
// - four sources: bus, external, hold, immediate
// - source write records; initiate activates it
// - external input granted to first claimer only
// - owner releases input on source change
// - claim on owned input refused with error
// - common trigger and group trigger both accepted
// - each accepted trigger advances one channel
// - reset opens, invalidates, arm one, immediate
// - source query returns BUS EXT HOLD IMM
// - clear status clears all event bits not set in the same cycle
// - common trigger needs scanning and bus source
module scan_trigger_source_control
  import scan_trig_pkg::*;
(
  input  wire logic                       clk_sys,     // system clock, 25 MHz
  input  wire logic                       arst_n,      // async reset, active low
  input  wire logic                       psel,        // apb select
  input  wire logic                       penable,     // apb access phase
  input  wire logic                       pwrite,      // apb direction
  input  wire logic [7:0]                 paddr,       // apb byte address
  input  wire logic [31:0]                pwdata,      // apb write data
  input  wire logic [3:0]                 pstrb,       // apb byte strobes
  output logic                            pready,      // apb ready
  output logic      [31:0]                prdata,      // apb read data
  output logic                            pslverr,     // apb error, unmapped address
  input  wire logic                       extTrigPin,  // shared external trigger pin
  input  wire logic [scan_trig_pkg::NBOX-2:0] otherClaim, // claims from other switchboxes
  input  wire logic [scan_trig_pkg::NBOX-2:0] otherRelease, // releases from other switchboxes
  output logic                            extOwned,    // this switchbox owns the input
  output logic      [scan_trig_pkg::CH_W-1:0] chanSel, // channel now closed
  output logic                            chanClosed,  // a channel is closed
  output logic                            irq          // interrupt, level high
);

  // register state
  trig_src_e        srcPend_r, srcPend_nxt;   // recorded selection
  trig_src_e        srcAct_r,  srcAct_nxt;    // source in force
  logic             armed_r,   armed_nxt;     // scanning initiated
  logic [CH_W-1:0]  first_r,   first_nxt;
  logic [CH_W-1:0]  last_r,    last_nxt;
  logic             listOk_r,  listOk_nxt;
  logic [CH_W-1:0]  chan_r,    chan_nxt;
  logic             closed_r,  closed_nxt;
  logic [ARM_W-1:0] armCnt_r,  armCnt_nxt;
  logic [ARM_W-1:0] armLeft_r, armLeft_nxt;
  logic             cont_r,    cont_nxt;
  logic [EV_W-1:0]  stat_r,    stat_nxt;
  logic [EV_W-1:0]  mask_r,    mask_nxt;
  logic [31:0]      rdata_r,   rdata_nxt;

  logic             wrAcc;
  logic             rdAcc;
  logic [CMD_W-1:0] cmd;
  logic             extRise;
  logic [NBOX-1:0]  owner;
  logic [NBOX-1:0]  refuse;
  logic             myClaim;
  logic             myRelease;
  logic             trigHit;
  logic             trigBad;
  logic             lastStep;
  logic [EV_W-1:0]  evSet;
  logic [31:0]      maskWord;

  // byte-lane write: each enabled lane takes the new byte, disabled lanes keep the old value
  function automatic logic [31:0] lanes(input logic [31:0] oldV, input logic [31:0] newV,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = oldV;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = newV[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ascii name of a source for the query register
  function automatic logic [31:0] srcName(input trig_src_e s);
    logic [31:0] n;
    unique case (s)
      SRC_BUS:  n = NAME_BUS;
      SRC_EXT:  n = NAME_EXT;
      SRC_HOLD: n = NAME_HOLD;
      SRC_IMM:  n = NAME_IMM;
    endcase
    return n;
  endfunction

  // the pin is asynchronous, so it is synchronised before anything looks at it
  ext_pulse_sync u_sync (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .pinIn     (extTrigPin),
    .risePulse (extRise)
  );

  // this switchbox is box 0 of the shared arbiter
  ext_trig_arbiter u_arb (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .claim   ({otherClaim, myClaim}),
    .relPulse ({otherRelease, myRelease}),
    .owner   (owner),
    .refuse  (refuse)
  );

  // apb answers in the access cycle with no wait states
  assign wrAcc   = psel && penable && pwrite;
  assign rdAcc   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (paddr > REG_ARMCNT || paddr[1:0] != 2'b00);
  assign cmd     = (wrAcc && paddr == REG_CMD) ? pwdata[CMD_W-1:0] : '0;

  // claim when initiate makes external active; release when it stops being so
  // an initiate without a valid list activates nothing, so it neither claims nor releases
  assign myClaim   = cmd[CMD_INIT] && listOk_r && srcPend_r == SRC_EXT && !owner[0];
  assign myRelease = owner[0] && ((cmd[CMD_INIT] && listOk_r && srcPend_r != SRC_EXT) || cmd[CMD_RESET]);

  // trigger qualification per active source
  always_comb begin
    trigHit = 1'b0;
    trigBad = 1'b0;
    if (armed_r && listOk_r) begin
      unique case (srcAct_r)
        SRC_BUS: begin
          trigHit = cmd[CMD_SWTRG] || cmd[CMD_BUSTRG] || cmd[CMD_GRPTRG];
          trigBad = 1'b0;
        end
        SRC_EXT: begin
          trigHit = extRise && owner[0];
          trigBad = cmd[CMD_SWTRG] || cmd[CMD_BUSTRG] || cmd[CMD_GRPTRG];
        end
        SRC_HOLD: begin
          trigHit = cmd[CMD_SWTRG];
          trigBad = cmd[CMD_BUSTRG] || cmd[CMD_GRPTRG];
        end
        SRC_IMM: begin
          trigHit = 1'b1;                                          // continuous
          trigBad = 1'b0;
        end
      endcase
    end else begin
      trigBad = cmd[CMD_SWTRG] || cmd[CMD_BUSTRG] || cmd[CMD_GRPTRG];
    end
  end

  assign lastStep = chan_r == last_r;

  // scan state, source selection and list
  always_comb begin
    srcPend_nxt = srcPend_r;
    srcAct_nxt  = srcAct_r;
    armed_nxt   = armed_r;
    first_nxt   = first_r;
    last_nxt    = last_r;
    listOk_nxt  = listOk_r;
    chan_nxt    = chan_r;
    closed_nxt  = closed_r;
    armCnt_nxt  = armCnt_r;
    armLeft_nxt = armLeft_r;
    cont_nxt    = cont_r;
    evSet       = '0;
    if (wrAcc && paddr == REG_SRCSEL) begin
      srcPend_nxt = trig_src_e'(pwdata[1:0]);
    end
    if (wrAcc && paddr == REG_LIST) begin
      first_nxt  = pwdata[CH_W-1:0];
      last_nxt   = pwdata[LIST_LAST +: CH_W];
      listOk_nxt = pwdata[LIST_VALID];
      armed_nxt  = 1'b0;
      closed_nxt = 1'b0;
    end
    if (wrAcc && paddr == REG_ARMCNT) begin
      armCnt_nxt = pwdata[ARM_W-1:0];
      cont_nxt   = pwdata[ARM_CONT];
    end
    if (cmd[CMD_ABORT]) begin
      armed_nxt  = 1'b0;
      closed_nxt = 1'b0;
    end
    if (cmd[CMD_INIT] && listOk_r) begin
      if (srcPend_r == SRC_EXT && refuse[0]) begin
        evSet[EV_EXTERR] = 1'b1;
      end else begin
        srcAct_nxt  = srcPend_r;
        armed_nxt   = 1'b1;
        chan_nxt    = first_r;
        closed_nxt  = 1'b1;
        armLeft_nxt = armCnt_r;
      end
    end else if (trigHit) begin
      evSet[EV_ADV] = 1'b1;
      if (lastStep) begin
        evSet[EV_DONE] = 1'b1;
        chan_nxt       = first_r;
        if (!cont_r && armLeft_r <= ARM_RST) begin
          armed_nxt  = 1'b0;
          closed_nxt = 1'b0;
        end else if (!cont_r) begin
          armLeft_nxt = armLeft_r - ARM_RST;
        end
      end else begin
        chan_nxt = chan_r + 1'b1;
      end
    end
    if (trigBad) begin
      evSet[EV_TRGERR] = 1'b1;
    end
    if (cmd[CMD_RESET]) begin
      closed_nxt  = 1'b0;
      listOk_nxt  = 1'b0;
      armed_nxt   = 1'b0;
      armCnt_nxt  = ARM_RST;
      srcPend_nxt = SRC_IMM;
      srcAct_nxt  = SRC_IMM;
      cont_nxt    = 1'b0;
    end
  end

  // sticky status: set beats write-one clear and clear status; clear status drops all other bits
  always_comb begin
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    maskWord = lanes({28'h0000000, mask_r}, pwdata, pstrb);
    if (wrAcc && paddr == REG_INTSTAT) begin
      stat_nxt = stat_nxt & ~pwdata[EV_W-1:0];
    end
    if (cmd[CMD_CLS]) begin
      stat_nxt = '0;
    end
    stat_nxt = stat_nxt | evSet;
    if (wrAcc && paddr == REG_INTMASK) begin
      mask_nxt = maskWord[EV_W-1:0];
    end
  end

  // read data registered in the setup cycle, valid in the access cycle
  always_comb begin
    rdata_nxt = rdata_r;
    if (rdAcc) begin
      unique case (paddr)
        REG_SRCSEL:  rdata_nxt = {30'h00000000, srcPend_r};
        REG_LIST:    rdata_nxt = {15'h0000, listOk_r, 4'h0, last_r, 4'h0, first_r};
        REG_STATE:   rdata_nxt = {20'h00000, chan_r, 1'b0, owner[0], srcAct_r,
                                   2'b00, closed_r, armed_r};
        REG_SRCNAME: rdata_nxt = srcName(srcAct_r);
        REG_INTSTAT: rdata_nxt = {28'h0000000, stat_r};
        REG_INTMASK: rdata_nxt = {28'h0000000, mask_r};
        REG_ARMCNT:  rdata_nxt = {15'h0000, cont_r, 8'h00, armCnt_r};
        default:     rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      srcPend_r <= SRC_IMM;
      srcAct_r  <= SRC_IMM;
      armed_r   <= 1'b0;
      first_r   <= '0;
      last_r    <= '0;
      listOk_r  <= 1'b0;
      chan_r    <= '0;
      closed_r  <= 1'b0;
      armCnt_r  <= ARM_RST;
      armLeft_r <= ARM_RST;
      cont_r    <= 1'b0;
      stat_r    <= '0;
      mask_r    <= '0;
      rdata_r   <= '0;
    end else begin
      srcPend_r <= srcPend_nxt;
      srcAct_r  <= srcAct_nxt;
      armed_r   <= armed_nxt;
      first_r   <= first_nxt;
      last_r    <= last_nxt;
      listOk_r  <= listOk_nxt;
      chan_r    <= chan_nxt;
      closed_r  <= closed_nxt;
      armCnt_r  <= armCnt_nxt;
      armLeft_r <= armLeft_nxt;
      cont_r    <= cont_nxt;
      stat_r    <= stat_nxt;
      mask_r    <= mask_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // outputs
  assign prdata     = rdata_r;
  assign extOwned   = owner[0];
  assign chanSel    = chan_r;
  assign chanClosed = closed_r;
  assign irq        = |(stat_r & mask_r);

endmodule
`default_nettype wire

// ==== scan_trig_assertions.sv ====
// checker: port-level assertions for the scan trigger control block
`timescale 1ns/1ps
`default_nettype none
module scan_trig_assertions
  import scan_trig_pkg::*;
(
  input wire logic                            clk_sys,      // system clock
  input wire logic                            arst_n,       // async reset, active low
  input wire logic                            psel,         // apb select
  input wire logic                            penable,      // apb access phase
  input wire logic                            pwrite,       // apb direction
  input wire logic [7:0]                      paddr,        // apb address
  input wire logic [31:0]                     pwdata,       // apb write data
  input wire logic [3:0]                      pstrb,        // apb strobes
  input wire logic                            pready,       // apb ready
  input wire logic [31:0]                     prdata,       // apb read data
  input wire logic                            pslverr,      // apb error
  input wire logic                            extTrigPin,   // external pin
  input wire logic [scan_trig_pkg::NBOX-2:0]  otherClaim,   // peer claims
  input wire logic [scan_trig_pkg::NBOX-2:0]  otherRelease, // peer releases
  input wire logic                            extOwned,     // input owned
  input wire logic [scan_trig_pkg::CH_W-1:0]  chanSel,      // channel
  input wire logic                            chanClosed,   // channel closed
  input wire logic                            irq           // interrupt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic cmdWr;
  logic othersHold_r;
  logic othersHold_nxt;
  // command register written at this edge
  assign cmdWr = psel && penable && pwrite && paddr == REG_CMD;
  // tracks a peer holding the input; simultaneous claims are not modelled
  always_comb begin
    othersHold_nxt = othersHold_r;
    if (|otherRelease) othersHold_nxt = 1'b0;
    else if (|otherClaim && !extOwned) othersHold_nxt = 1'b1;
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) othersHold_r <= 1'b0;
    else othersHold_r <= othersHold_nxt;
  end
  property p_own_init; $rose(extOwned) |-> $past(cmdWr && pwdata[CMD_INIT]); endproperty
  a_own_init:
    assert property (p_own_init) else $error("ownership gained without initiate");
  property p_refuse; othersHold_r && !extOwned |=> !extOwned; endproperty
  a_refuse:
    assert property (p_refuse) else $error("input taken from another owner");
  property p_rst_cmd; cmdWr && pwdata[CMD_RESET] |=> ##1 (!extOwned && !chanClosed); endproperty
  a_rst_cmd:
    assert property (p_rst_cmd) else $error("reset command left channel or input held");
  property p_cls; cmdWr && pwdata == (32'h1 << CMD_CLS) && !chanClosed |-> ##3 !irq; endproperty
  a_cls:
    assert property (p_cls) else $error("interrupt stays after clear status");
  property p_idle; !chanClosed && !psel && !$past(psel) |=> $stable(chanSel); endproperty
  a_idle:
    assert property (p_idle) else $error("channel moved while not scanning");
  property p_slverr; psel && penable && paddr > REG_ARMCNT |-> pslverr && pready; endproperty
  a_slverr:
    assert property (p_slverr) else $error("no error on unmapped access");
  property p_badrd; psel && !penable && !pwrite && paddr > REG_ARMCNT |=> prdata == 32'h0; endproperty
  a_badrd:
    assert property (p_badrd) else $error("unmapped read not zero");
  property p_wake; $rose(arst_n) |-> !irq && !extOwned && !chanClosed && prdata == 32'h0; endproperty
  a_wake:
    assert property (p_wake) else $error("outputs not idle after reset");
endmodule
bind scan_trigger_source_control scan_trig_assertions u_chk (.clk_sys, .arst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .extTrigPin, .otherClaim, .otherRelease, .extOwned,
  .chanSel, .chanClosed, .irq);
`default_nettype wire

// ==== peer_boxes.sv ====
// partner model: the other switchboxes sharing the external trigger input
`timescale 1ns/1ps
`default_nettype none
module peer_boxes
  import scan_trig_pkg::*;
(
  input  wire logic                           clk_sys,      // system clock
  output logic [scan_trig_pkg::NBOX-2:0]      otherClaim,   // claim pulses
  output logic [scan_trig_pkg::NBOX-2:0]      otherRelease  // release pulses
);
  // idle until a box asks
  initial begin
    otherClaim = '0;
    otherRelease = '0;
  end
  // one-cycle request of box idx+1, trailing idle edge keeps pulses apart
  task automatic pulse(input logic rel, input int idx);
    if (rel) otherRelease[idx] <= 1'b1;
    else otherClaim[idx] <= 1'b1;
    @(posedge clk_sys);
    otherClaim <= '0;
    otherRelease <= '0;
    @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ==== test_scan_trigger_source_control.sv ====
// testbench: scenarios for the scan trigger control block
`timescale 1ns/1ps
`default_nettype none
module test_scan_trigger_source_control;
  import scan_trig_pkg::*;
  logic                   clk_sys, arst_n, psel, penable, pwrite, pready, pslverr;
  logic                   extTrigPin, extOwned, chanClosed, irq, lastErr;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata, rd;
  logic [3:0]             pstrb;
  logic [NBOX-2:0]        otherClaim, otherRelease;
  logic [CH_W-1:0]        chanSel, first;
  int                     errorCnt, numChecks;

  scan_trigger_source_control u_dut (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .extTrigPin, .otherClaim, .otherRelease, .extOwned, .chanSel, .chanClosed, .irq);
  peer_boxes u_peer (.clk_sys, .otherClaim, .otherRelease);

  // 25 MHz clock
  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, entered just after an edge; only the watchdog ends a wait for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin @(posedge clk_sys); end while (pready !== 1'b1);
    rd = prdata;
    lastErr = pslverr;
    chk("pslverr", 32'(a > REG_ARMCNT || a[1:0] != 2'b00), 32'(lastErr));
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task rdr(input logic [7:0] a); apb(1'b0, a, 32'h0); endtask
  task cmd(input int b); wr(REG_CMD, 32'h1 << b); endtask
  // outputs are judged mid-cycle, where they have settled
  task mid; @(negedge clk_sys); endtask
  task edge1; @(posedge clk_sys); endtask
  task seeCh(input string what, input logic [31:0] exp); mid; chk(what, exp, 32'(chanSel)); edge1; endtask

  task t_defaults;
    rdr(REG_SRCSEL); chk("srcsel", 32'h3, 32'(rd[1:0]));
    rdr(REG_ARMCNT); chk("armcnt", 32'h1, rd);
    rdr(REG_SRCNAME); chk("name", NAME_IMM, rd);
    rdr(8'h20); chk("unmapped err", 32'h1, 32'(lastErr));
    chk("unmapped data", 32'h0, rd);
    $display("defaults done");
  endtask
  task t_hold;
    wr(REG_LIST, 32'h00010502);
    wr(REG_SRCSEL, 32'(SRC_HOLD));
    rdr(REG_SRCNAME); chk("name before init", NAME_IMM, rd);
    cmd(CMD_INIT); seeCh("first channel", 32'h2);
    mid; chk("closed after init", 32'h1, 32'(chanClosed)); edge1;
    cmd(CMD_SWTRG); seeCh("sw trig hold", 32'h3);
    rdr(REG_SRCNAME); chk("hold kept", NAME_HOLD, rd);
    cmd(CMD_BUSTRG); seeCh("common trig in hold", 32'h3);
    rdr(REG_INTSTAT); chk("ignored flag", 32'h1, 32'(rd[EV_TRGERR]));
    $display("hold done");
  endtask
  task t_bus;
    wr(REG_SRCSEL, 32'(SRC_BUS));
    cmd(CMD_INIT); seeCh("bus first", 32'h2);
    cmd(CMD_BUSTRG); seeCh("common trig", 32'h3);
    cmd(CMD_GRPTRG); seeCh("group trig", 32'h4);
    cmd(CMD_SWTRG); seeCh("sw trig bus", 32'h5);
    rdr(REG_SRCNAME); chk("bus name", NAME_BUS, rd);
    $display("bus done");
  endtask
  task t_nolist;
    wr(REG_LIST, 32'h00000502);
    wr(REG_SRCSEL, 32'(SRC_HOLD));
    cmd(CMD_INIT);
    cmd(CMD_SWTRG);
    mid; chk("armed without list", 32'h0, 32'(chanClosed)); edge1;
    $display("no list done");
  endtask
  task t_imm;
    wr(REG_LIST, 32'h00010502);
    wr(REG_ARMCNT, 32'h00010001);
    wr(REG_SRCSEL, 32'(SRC_IMM));
    cmd(CMD_INIT);
    mid; first = chanSel; edge1;
    seeCh("imm step", (first == 4'h5) ? 32'h2 : 32'(first + 4'h1));
    wr(REG_INTMASK, 32'h1);
    mid; chk("irq on advance", 32'h1, 32'(irq)); edge1;
    cmd(CMD_ABORT);
    cmd(CMD_CLS);
    rdr(REG_INTSTAT); chk("status cleared", 32'h0, rd);
    $display("immediate done");
  endtask
  task t_ext;
    wr(REG_INTMASK, 32'h4);
    u_peer.pulse(1'b0, 0);
    wr(REG_SRCSEL, 32'(SRC_EXT));
    cmd(CMD_INIT);
    mid; chk("ext refused", 32'h0, 32'(extOwned)); chk("irq raised", 32'h1, 32'(irq)); edge1;
    rdr(REG_INTSTAT); chk("refused flag", 32'h1, 32'(rd[EV_EXTERR]));
    wr(REG_INTSTAT, 32'h4);
    edge1;
    mid; chk("irq cleared", 32'h0, 32'(irq)); edge1;
    u_peer.pulse(1'b1, 0);
    cmd(CMD_INIT);
    mid; chk("ext granted", 32'h1, 32'(extOwned)); edge1;
    extTrigPin <= 1'b1;
    repeat (6) edge1;
    seeCh("ext trig", 32'h3);
    extTrigPin <= 1'b0;
    wr(REG_SRCSEL, 32'(SRC_HOLD));
    cmd(CMD_INIT);
    mid; chk("ext released", 32'h0, 32'(extOwned)); edge1;
    $display("external done");
  endtask
  task t_reset;
    wr(REG_ARMCNT, 32'h00010003);
    cmd(CMD_RESET);
    mid; chk("open after reset", 32'h0, 32'(chanClosed)); edge1;
    rdr(REG_SRCNAME); chk("reset name", NAME_IMM, rd);
    rdr(REG_ARMCNT); chk("reset armcnt", 32'h1, rd);
    rdr(REG_LIST); chk("list invalid", 32'h0, 32'(rd[LIST_VALID]));
    $display("reset done");
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog well beyond the roughly 170 cycles the tests need
  initial begin
    #800000;
    errorCnt++;
    $display("watchdog expired");
    conclude();
  end
  // reset, then the scenarios in order
  initial begin
    arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; pstrb = 4'hf; extTrigPin = 1'b0; errorCnt = 0; numChecks = 0;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    edge1;
    t_defaults();
    t_hold();
    t_bus();
    t_nolist();
    t_imm();
    t_ext();
    t_reset();
    conclude();
  end
endmodule
`default_nettype wire
